// [design/gal_group_abs_linear.sv]
// Group absolute linear move command block with execute handshake
`timescale 1ns/1ps
`include "gal_params.svh"

module gal_group_abs_linear (
  input  wire logic                          core_clk_in,
  input  wire logic                          nrst_in,
  input  wire logic                          en_in,
  input  wire logic                          execute_in,
  input  wire logic [15:0]                   axis_group_select_in,
  input  wire logic [`GAL_AXES-1:0][`GAL_POS_W-1:0] target_pos_in,
  input  wire gal_pkg::gal_word_t            speed_in,
  input  wire logic [2:0]                    queueing_behaviour_in,
  input  wire logic [15:0]                   corner_blend_select_in,
  input  wire logic [2:0]                    group_axes_enabled_in,
  input  wire logic                          motion_started_in,
  input  wire logic                          target_reached_in,
  input  wire logic                          preempt_in,
  input  wire logic                          motion_fault_in,
  input  wire gal_pkg::gal_word_t            motion_fault_code_in,
  output logic                               eno_out,
  output logic                               move_req_out,
  output logic [15:0]                        axis_group_select_out,
  output logic [`GAL_AXES-1:0][`GAL_POS_W-1:0] target_pos_out,
  output gal_pkg::gal_word_t                 speed_out,
  output logic [2:0]                         queueing_behaviour_out,
  output logic [1:0]                         corner_blend_select_out,
  output logic                               done_out,
  output logic                               busy_out,
  output logic                               active_out,
  output logic                               aborted_out,
  output logic                               error_out,
  output gal_pkg::gal_word_t                 fault_code_out
);
  import gal_pkg::*;

  gal_regs_s q;
  gal_regs_s d;

  logic      exec_rise;
  logic      bad_group;
  logic      bad_axes;
  logic      bad_speed;
  logic      bad_queue;
  logic      bad_blend;
  gal_word_t input_code;

  // ----------------------------------------------------------------
  // Input checks at capture
  // ----------------------------------------------------------------
  assign exec_rise = execute_in && !q.exec_prev;
  assign bad_group = (axis_group_select_in < `GAL_GROUP_MIN) ||
                     (axis_group_select_in > `GAL_GROUP_MAX);
  assign bad_axes  = group_axes_enabled_in < `GAL_MIN_AXES;
  assign bad_speed = speed_in[`GAL_POS_W-1] || (speed_in == '0);
  assign bad_queue = queueing_behaviour_in > `GAL_QUEUE_MAX;
  assign bad_blend = corner_blend_select_in > `GAL_BLEND_MAX;

  always_comb begin
    if (bad_group) begin
      input_code = `GAL_ERR_GROUP;
    end else if (bad_axes) begin
      input_code = `GAL_ERR_AXES;
    end else if (bad_speed) begin
      input_code = `GAL_ERR_SPEED;
    end else if (bad_queue) begin
      input_code = `GAL_ERR_QUEUE;
    end else if (bad_blend) begin
      input_code = `GAL_ERR_BLEND;
    end else begin
      input_code = `GAL_RST_CODE;
    end
  end

  // ----------------------------------------------------------------
  // Handshake state machine
  // ----------------------------------------------------------------
  always_comb begin
    d          = q;
    d.move_req = 1'b0;
    if (en_in) begin
      d.exec_prev = execute_in;
      case (q.st)
        GAL_IDLE: begin
          if (exec_rise && !q.busy) begin
            d.group = axis_group_select_in;
            d.tgt   = target_pos_in;
            d.speed = speed_in;
            d.queue = queueing_behaviour_in;
            d.blend = corner_blend_select_in[1:0];
            if (input_code != `GAL_RST_CODE) begin
              d.error = 1'b1;
              d.code  = input_code;
              d.st    = GAL_FINISH;
            end else begin
              d.busy     = 1'b1;
              d.move_req = 1'b1;
              d.st       = GAL_START;
            end
          end
        end
        GAL_START, GAL_MOVE: begin
          if (q.active && !execute_in) begin
            d.active = 1'b0;
          end
          if (preempt_in) begin
            d.aborted = 1'b1;
            d.busy    = 1'b0;
            d.active  = 1'b0;
            d.st      = GAL_FINISH;
          end else if (motion_fault_in) begin
            d.error  = 1'b1;
            d.code   = motion_fault_code_in;
            d.busy   = 1'b0;
            d.active = 1'b0;
            d.st     = GAL_FINISH;
          end else if (q.st == GAL_MOVE && target_reached_in) begin
            d.done   = 1'b1;
            d.busy   = 1'b0;
            d.active = 1'b0;
            d.st     = GAL_FINISH;
          end else if (q.st == GAL_START && motion_started_in) begin
            d.active = 1'b1;
            d.st     = GAL_MOVE;
          end
        end
        GAL_FINISH: begin
          // Results stand while execute is held; one cycle if it is already low
          if (!execute_in) begin
            d.done    = 1'b0;
            d.aborted = 1'b0;
            d.error   = 1'b0;
            d.code    = `GAL_RST_CODE;
            d.st      = GAL_IDLE;
          end
        end
        default: begin
          d.st = GAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q.st        <= GAL_IDLE;
      q.exec_prev <= 1'b0;
      q.group     <= `GAL_RST_GROUP;
      q.tgt       <= '0;
      q.speed     <= `GAL_RST_POS;
      q.queue     <= 3'h0;
      q.blend     <= 2'h0;
      q.move_req  <= 1'b0;
      q.done      <= 1'b0;
      q.busy      <= 1'b0;
      q.active    <= 1'b0;
      q.aborted   <= 1'b0;
      q.error     <= 1'b0;
      q.code      <= `GAL_RST_CODE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign eno_out                 = en_in;
  assign move_req_out            = q.move_req;
  assign axis_group_select_out   = q.group;
  assign target_pos_out          = q.tgt;
  assign speed_out               = q.speed;
  assign queueing_behaviour_out  = q.queue;
  assign corner_blend_select_out = q.blend;
  assign done_out                = q.done;
  assign busy_out                = q.busy;
  assign active_out              = q.active;
  assign aborted_out             = q.aborted;
  assign error_out               = q.error;
  assign fault_code_out          = q.code;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_group_in_range: assert property (
    move_req_out |-> (axis_group_select_out >= `GAL_GROUP_MIN) &&
                     (axis_group_select_out <= `GAL_GROUP_MAX))
    else $error("move issued with group out of range");

  a_target_capture: assert property (
    en_in && exec_rise && !busy_out && q.st == GAL_IDLE && (input_code == `GAL_RST_CODE)
    |=> move_req_out && (target_pos_out == $past(target_pos_in)))
    else $error("targets not captured with the move request");

  a_capture_hold: assert property (
    busy_out && $past(busy_out) |-> $stable(target_pos_out) && $stable(speed_out) &&
                                     $stable(axis_group_select_out))
    else $error("captured inputs changed while busy");

  a_blend_legal: assert property (
    move_req_out |-> corner_blend_select_out <= 2'h2)
    else $error("illegal corner blend forwarded");

  a_done_on_reach: assert property (
    en_in && q.st == GAL_MOVE && target_reached_in && !preempt_in && !motion_fault_in
    |=> done_out && !busy_out && !active_out)
    else $error("done missing after targets reached");

  a_done_pulse: assert property (
    en_in && done_out && !execute_in |=> !done_out)
    else $error("done held after execute low");

  a_busy_drops: assert property (
    $rose(done_out) || $rose(error_out) || $rose(aborted_out) |-> !busy_out && !active_out)
    else $error("busy still high at end of move");

  a_active_pulse: assert property (
    en_in && $rose(active_out) && !execute_in && !preempt_in |=> !active_out)
    else $error("active held without execute");

  a_abort_sets: assert property (
    en_in && busy_out && preempt_in |=> aborted_out && !busy_out)
    else $error("preempt did not abort the move");

  a_abort_pulse: assert property (
    en_in && aborted_out && !execute_in |=> !aborted_out)
    else $error("aborted held after execute low");

  a_error_clear: assert property (
    en_in && error_out && !execute_in |=> !error_out && fault_code_out == `GAL_RST_CODE)
    else $error("error or code not cleared");

  a_speed_reject: assert property (
    en_in && exec_rise && !busy_out && q.st == GAL_IDLE && !bad_group && !bad_axes &&
    bad_speed |=> error_out && fault_code_out == `GAL_ERR_SPEED && !busy_out)
    else $error("bad speed not rejected");

  a_freeze_off: assert property (
    !en_in |=> !move_req_out && $stable({q.st, q.exec_prev, q.group, q.tgt, q.busy, q.done}) &&
               $stable({q.active, q.aborted, q.error, q.code}) && (eno_out == en_in))
    else $error("state moved while disabled");

  a_req_pulse: assert property (
    move_req_out |=> !move_req_out)
    else $error("move request longer than one cycle");

  a_req_busy: assert property (
    move_req_out |-> busy_out)
    else $error("move request without busy");

  a_group_capture: assert property (
    en_in && exec_rise && q.st == GAL_IDLE && (input_code == `GAL_RST_CODE)
    |=> axis_group_select_out == $past(axis_group_select_in) && speed_out == $past(speed_in) &&
        queueing_behaviour_out == $past(queueing_behaviour_in))
    else $error("group, speed or queueing not captured");

  a_blend_capture: assert property (
    en_in && exec_rise && q.st == GAL_IDLE && (input_code == `GAL_RST_CODE)
    |=> corner_blend_select_out == $past(corner_blend_select_in[1:0]))
    else $error("corner blend not captured");

  a_input_error: assert property (
    en_in && exec_rise && q.st == GAL_IDLE && (input_code != `GAL_RST_CODE)
    |=> error_out && !busy_out && !move_req_out && fault_code_out == $past(input_code))
    else $error("input error not reported");

  a_fault_code: assert property (
    en_in && busy_out && !preempt_in && motion_fault_in
    |=> error_out && !busy_out && fault_code_out == $past(motion_fault_code_in))
    else $error("engine fault code not passed on");

  a_one_result: assert property (
    $onehot0({done_out, aborted_out, error_out}))
    else $error("more than one result showing");

  a_active_busy: assert property (
    active_out |-> busy_out)
    else $error("active without busy");

  a_done_holds: assert property (
    en_in && done_out && execute_in |=> done_out)
    else $error("done dropped while execute high");

  a_abort_holds: assert property (
    en_in && aborted_out && execute_in |=> aborted_out)
    else $error("aborted dropped while execute high");

  a_error_holds: assert property (
    en_in && error_out && execute_in |=> error_out && $stable(fault_code_out))
    else $error("error or code changed while execute high");

  a_code_idle: assert property (
    !error_out |-> fault_code_out == `GAL_RST_CODE)
    else $error("fault code set without error");

  a_active_rise: assert property (
    $rose(active_out) |-> $past(en_in) && $past(motion_started_in))
    else $error("active rose without motion start");

  c_done_seen:    cover property (move_req_out ##[1:50] $rose(done_out));
  c_abort_seen:   cover property (active_out ##1 $rose(aborted_out));
  c_error_seen:   cover property ($rose(error_out) && fault_code_out == `GAL_ERR_AXES);
  c_active_pulse: cover property ($rose(active_out) && !execute_in);
  c_blend_round:  cover property (move_req_out && corner_blend_select_out == 2'h2);

endmodule : gal_group_abs_linear

// [shared/gal_params.svh]
// Constants for the group absolute linear move block
`ifndef GAL_PARAMS_SVH
`define GAL_PARAMS_SVH

`define GAL_POS_W        32
`define GAL_AXES         6
`define GAL_GROUP_MIN    16'h0001
`define GAL_GROUP_MAX    16'h0010
`define GAL_MIN_AXES     3'h2
`define GAL_QUEUE_MAX    3'h5
`define GAL_BLEND_MAX    16'h0002

`define GAL_RST_GROUP    16'h0000
`define GAL_RST_POS      32'h0000_0000
`define GAL_RST_CODE     32'h0000_0000

`define GAL_ERR_GROUP    32'h0000_0001
`define GAL_ERR_AXES     32'h0000_0002
`define GAL_ERR_SPEED    32'h0000_0003
`define GAL_ERR_QUEUE    32'h0000_0004
`define GAL_ERR_BLEND    32'h0000_0005

`endif

// [shared/gal_pkg.sv]
// Types for the group absolute linear move block
`include "gal_params.svh"

package gal_pkg;

  typedef logic [`GAL_POS_W-1:0] gal_word_t;

  // Gray codes along idle -> start -> move -> finish
  typedef enum logic [1:0] {
    GAL_IDLE   = 2'h0,
    GAL_START  = 2'h1,
    GAL_MOVE   = 2'h3,
    GAL_FINISH = 2'h2
  } gal_state_e;

  typedef struct packed {
    gal_state_e                   st;
    logic                         exec_prev;
    logic [15:0]                  group;
    logic [`GAL_AXES-1:0][`GAL_POS_W-1:0] tgt;
    gal_word_t                    speed;
    logic [2:0]                   queue;
    logic [1:0]                   blend;
    logic                         move_req;
    logic                         done;
    logic                         busy;
    logic                         active;
    logic                         aborted;
    logic                         error;
    gal_word_t                    code;
  } gal_regs_s;

endpackage : gal_pkg

// [dv/gal_engine_model.sv]
// Motion engine stand-in that answers move requests from the block
`timescale 1ns/1ps
module gal_engine_model (
  input  wire logic        core_clk_in,
  input  wire logic        move_req_in,
  input  wire logic [1:0]  mode_in,
  output logic             started_out,
  output logic             reached_out,
  output logic             preempt_out,
  output logic             fault_out,
  output logic [31:0]      fault_code_out
);
  localparam logic [31:0] FAULT_CODE = 32'h0000_0abc;
  // Mode 0 reach, 1 preempt, 2 fault, 3 slow reach; code toggles between moves and holds during one
  initial begin
    {started_out, reached_out, preempt_out, fault_out} = 4'h0;
    fault_code_out = 32'h5555_aaaa;
    forever begin
      @(posedge core_clk_in);
      if (move_req_in === 1'b1) begin
        started_out <= 1'b1;
        repeat ((mode_in == 2'h3) ? 12 : 4) @(posedge core_clk_in);
        case (mode_in)
          2'h1: preempt_out <= 1'b1;
          2'h2: begin
            fault_out <= 1'b1;
            fault_code_out <= FAULT_CODE;
          end
          default: reached_out <= 1'b1;
        endcase
        @(posedge core_clk_in);
        {started_out, reached_out, preempt_out, fault_out} <= 4'h0;
        fault_code_out <= ~FAULT_CODE;
      end else begin
        fault_code_out <= ~fault_code_out;
      end
    end
  end
endmodule : gal_engine_model

// [dv/test_group_absolute_linear_move.sv]
// Self-checking bench for the group absolute linear move block
`timescale 1ns/1ps
`include "gal_params.svh"
module test_group_absolute_linear_move;
  import gal_pkg::*;
  localparam logic [31:0] FAULT_CODE = 32'h0000_0abc;
  logic clk, nrst, en, exec, st, rc, pre, flt, mreq, eno, done, busy, act, abo, err;
  logic [15:0] grp, blend, grp_o;
  logic [2:0] queue, axes, queue_o;
  logic [1:0] mode, blend_o;
  logic [`GAL_AXES-1:0][`GAL_POS_W-1:0] tgt, tgt_o;
  gal_word_t speed, fcode, speed_o, code;
  int fails, compares;

  gal_group_abs_linear DUT (.core_clk_in(clk), .nrst_in(nrst), .en_in(en), .execute_in(exec),
    .axis_group_select_in(grp), .target_pos_in(tgt), .speed_in(speed),
    .queueing_behaviour_in(queue), .corner_blend_select_in(blend), .group_axes_enabled_in(axes),
    .motion_started_in(st), .target_reached_in(rc), .preempt_in(pre), .motion_fault_in(flt),
    .motion_fault_code_in(fcode), .eno_out(eno), .move_req_out(mreq),
    .axis_group_select_out(grp_o), .target_pos_out(tgt_o), .speed_out(speed_o),
    .queueing_behaviour_out(queue_o), .corner_blend_select_out(blend_o), .done_out(done),
    .busy_out(busy), .active_out(act), .aborted_out(abo), .error_out(err), .fault_code_out(code));
  gal_engine_model engine (.core_clk_in(clk), .move_req_in(mreq), .mode_in(mode),
    .started_out(st), .reached_out(rc), .preempt_out(pre), .fault_out(flt), .fault_code_out(fcode));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic setup(input logic [15:0] g, input logic [2:0] a, input gal_word_t s,
                       input logic [2:0] q, input logic [15:0] b);
    logic [`GAL_AXES-1:0][`GAL_POS_W-1:0] pos;
    for (int i = 0; i < `GAL_AXES; i++) pos[i] = 32'(i * 1000) - 32'h0000_0bb8 + 32'(g);
    @(posedge clk);
    grp <= g;
    axes <= a;
    speed <= s;
    queue <= q;
    blend <= b;
    tgt <= pos;
    exec <= 1'b1;
    #1;
  endtask : setup

  task automatic t_move(input logic [15:0] g, input logic [2:0] q, input logic [15:0] b,
                        input logic [1:0] md, input bit hold);
    logic [`GAL_AXES-1:0][`GAL_POS_W-1:0] cap;
    int nd, na, ne, nv, nr, k;
    {nd, na, ne, nv, nr, k} = '0;
    mode = md;
    setup(g, 3'h2, 32'h0000_0100, q, b);
    cap = tgt;
    while (mreq !== 1'b1 && k < 4) begin
      cyc(1);
      k++;
    end
    chk(busy, 1, "busy at start");
    chk({31'h0, tgt_o === cap}, 1, "targets captured");
    chk(grp_o, g, "group captured");
    chk({27'h0, blend_o, queue_o}, {27'h0, b[1:0], q}, "modes captured");
    chk(speed_o, 32'h0000_0100, "speed captured");
    @(posedge clk);
    grp <= 16'h0007;
    tgt <= '0;
    blend <= 16'h0000;
    if (!hold) exec <= 1'b0;
    for (int i = 0; i < 30; i++) begin
      cyc(1);
      nd += (done === 1'b1);
      na += (abo === 1'b1);
      ne += (err === 1'b1);
      nv += (act === 1'b1);
      nr += (mreq === 1'b1);
    end
    chk({grp_o, blend_o}, {g, b[1:0]}, "capture held");
    chk(nr, 0, "request pulse");
    chk(busy, 0, "busy after result");
    chk(act, 0, "active after result");
    if (!hold) begin
      chk(nd, {31'h0, md[0] == md[1]}, "done pulses");
      chk(na, {31'h0, md == 2'h1}, "aborted pulses");
      chk(ne, {31'h0, md == 2'h2}, "error pulses");
      chk(nv, 1, "active pulse");
    end else begin
      chk({done, abo, err}, {md[0] == md[1], md == 2'h1, md == 2'h2}, "result");
      chk(code, (md == 2'h2) ? FAULT_CODE : 32'h0, "fault code");
      @(posedge clk);
      exec <= 1'b0;
      cyc(2);
      chk({done, abo, err}, 0, "result cleared");
      chk(code, 0, "code cleared");
    end
  endtask : t_move

  task automatic t_bad(input logic [15:0] g, input logic [2:0] a, input gal_word_t s,
                       input logic [2:0] q, input logic [15:0] b, input gal_word_t c);
    int k;
    k = 0;
    setup(g, a, s, q, b);
    while (err !== 1'b1 && k < 4) begin
      cyc(1);
      k++;
    end
    chk({err, busy}, 2'h2, "input error");
    chk(code, c, "error code");
    @(posedge clk);
    exec <= 1'b0;
    cyc(2);
    chk(err, 0, "error cleared");
    chk(code, 0, "error code cleared");
  endtask : t_bad

  task automatic t_en;
    @(posedge clk);
    en <= 1'b0;
    exec <= 1'b1;
    cyc(3);
    chk({eno, busy, mreq}, 0, "frozen while disabled");
    @(posedge clk);
    exec <= 1'b0;
    cyc(1);
    @(posedge clk);
    en <= 1'b1;
    cyc(2);
    chk({eno, busy}, 2'h2, "enabled again");
  endtask : t_en

  task automatic summarize;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    #(25 * 4000);
    fails++;
    $display("BAD t=%0t watchdog expired", $time);
    summarize();
  end

  initial begin
    {nrst, exec, grp, axes, speed, queue, blend, mode, fails, compares} = '0;
    en = 1'b1;
    tgt = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    cyc(1);
    chk({busy, done, act, abo, err, mreq, grp_o}, 0, "reset state");
    chk({31'h0, tgt_o === '0}, 1, "targets reset");
    chk(code, 0, "code reset");
    t_move(16'h0001, 3'h0, 16'h0000, 2'h0, 1'b1);
    t_move(16'h0010, 3'h1, 16'h0001, 2'h3, 1'b0);
    t_move(16'h0005, 3'h2, 16'h0002, 2'h1, 1'b0);
    t_move(16'h0005, 3'h3, 16'h0000, 2'h1, 1'b1);
    t_move(16'h0003, 3'h4, 16'h0001, 2'h2, 1'b1);
    t_bad(16'h0000, 3'h2, 32'h100, 3'h5, 16'h0, `GAL_ERR_GROUP);
    t_bad(16'h0011, 3'h2, 32'h100, 3'h5, 16'h0, `GAL_ERR_GROUP);
    t_bad(16'h0002, 3'h1, 32'h100, 3'h5, 16'h0, `GAL_ERR_AXES);
    t_bad(16'h0002, 3'h6, 32'h0, 3'h5, 16'h0, `GAL_ERR_SPEED);
    t_bad(16'h0002, 3'h2, 32'hffff_ff00, 3'h5, 16'h0, `GAL_ERR_SPEED);
    t_bad(16'h0002, 3'h2, 32'h100, 3'h6, 16'h0, `GAL_ERR_QUEUE);
    t_bad(16'h0002, 3'h2, 32'h100, 3'h5, 16'h3, `GAL_ERR_BLEND);
    t_en();
    summarize();
  end
endmodule : test_group_absolute_linear_move
